/* core/dead_time_pair.sv */
// Complementary dead-time insertion for one generator pin pair
`timescale 1ns/1ps

module dead_time_pair
  import pwm_out_pkg::*;
(
  input  wire logic                mclk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                raw_i,
  input  wire logic                act_sel_i,
  input  wire logic                inact_sel_i,
  input  wire pwm_out_pkg::reg16_t dt_cfg_i,
  output logic                     high_o,
  output logic                     low_o
);
  import pwm_out_pkg::*;

  dt_state_t state_q;
  logic      raw_q;
  dt_cnt_t   cnt_q;
  logic      high_q;
  logic      low_q;

  wire dt_cnt_t dly_a = dead_cycles(dt_cfg_i[DT_A_VAL_LSB +: 6],
                                    dt_cfg_i[DT_A_PS_LSB +: 2]);
  wire dt_cnt_t dly_b = dead_cycles(dt_cfg_i[DT_B_VAL_LSB +: 6],
                                    dt_cfg_i[DT_B_PS_LSB +: 2]);
  wire logic    edge_hit = raw_i != raw_q;
  // Rising raw is the active-going edge, falling the inactive-going one
  wire logic    use_b = raw_i ? act_sel_i : inact_sel_i;
  wire dt_cnt_t dly = use_b ? dly_b : dly_a;

  // Any edge first drops both pins, so a restart mid-wait stays safe
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= DT_WAIT;
      raw_q   <= 1'b0;
      cnt_q   <= '0;
      high_q  <= 1'b0;
      low_q   <= 1'b0;
    end
    else if (edge_hit)
    begin
      raw_q   <= raw_i;
      high_q  <= 1'b0;
      low_q   <= 1'b0;
      cnt_q   <= dly;
      state_q <= DT_WAIT;
    end
    else
    begin
      case (state_q)
        DT_WAIT:
          if (cnt_q == '0)
          begin
            high_q  <= raw_q;
            low_q   <= ~raw_q;
            state_q <= DT_IDLE;
          end
          else
            cnt_q <= cnt_q - 9'h001;
        default: state_q <= DT_IDLE;
      endcase
    end
  end

  assign high_o = high_q;
  assign low_o  = low_q;

  property p_no_overlap;
    @(posedge mclk_i) disable iff (sys_rst_i)
    !(high_q && low_q);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("high and low pins active together");

  property p_active_unit;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (raw_i && !raw_q) |=>
      cnt_q == ($past(act_sel_i) ? $past(dly_b) : $past(dly_a));
  endproperty
  a_active_unit: assert property (p_active_unit)
    else $error("wrong dead-time unit on active-going edge");

  property p_inactive_unit;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (!raw_i && raw_q) |=> cnt_q == ($past(inact_sel_i) ? $past(dly_b)
                                                       : $past(dly_a));
  endproperty
  a_inactive_unit: assert property (p_inactive_unit)
    else $error("wrong dead-time unit on inactive-going edge");

  property p_step_one;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (edge_hit && raw_i && !act_sel_i && dt_cfg_i[7:0] == 8'h01)
      |=> (!high_q) [*2] ##1 (high_q || $changed(raw_q) || edge_hit);
  endproperty
  a_step_one: assert property (p_step_one)
    else $error("dead time of one unit step mistimed");

endmodule : dead_time_pair

/* core/motor_pwm_output_stage.sv */
// PWM output stage: dead-time select, fault override, manual override, duty
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps

// How it works
// - Bits 5, 3 and 1 pick dead-time unit B (set) or A for generators three, two and one on the active-going edge.
// - Bits 4, 2 and 0 pick unit B (set) or A for the same generators on the inactive-going edge.
// - Six fault level bits, one per pin, give the pin level forced during a fault: set is active.
// - With the fault mode bit set, forcing lasts until the first time base boundary after the fault clears.
// - With the mode bit clear, a fault latches enabled pins at their fault levels until released.
// - Three fault enable bits put each pin pair under fault control or leave it alone.
// - Each pin's override select bit, reset to one, gives the pin to the generator; clear gives it to the manual bit.
// - With the select bit clear, the manual bit drives the pin active when set and inactive when clear.
// - Three 16-bit software-writable duty values reset to zero.
// - A module with a single pin pair applies its select, fault and override controls to pair one only.
// - Bits 15 to 6 of the dead-time select register read as zero.
// - Each dead-time unit counts in steps of 1, 2, 4 or 8 clock cycles chosen by a two-bit code.
// - With override sync on, override changes apply at the time base boundary, else on the next cycle.
// - With immediate update on, duty writes take effect at once, else at the time base boundary.
module motor_pwm_output_stage
  import pwm_out_pkg::*;
#(
  parameter int unsigned PAIR_COUNT = 3
)
(
  input  wire logic                mclk_i,
  input  wire logic                sys_rst_i,
  input  wire pwm_out_pkg::addr_t  s_axi_awaddr_i,
  input  wire logic                s_axi_awvalid_i,
  output logic                     s_axi_awready_o,
  input  wire logic [31:0]         s_axi_wdata_i,
  input  wire logic [3:0]          s_axi_wstrb_i,
  input  wire logic                s_axi_wvalid_i,
  output logic                     s_axi_wready_o,
  output logic [1:0]               s_axi_bresp_o,
  output logic                     s_axi_bvalid_o,
  input  wire logic                s_axi_bready_i,
  input  wire pwm_out_pkg::addr_t  s_axi_araddr_i,
  input  wire logic                s_axi_arvalid_i,
  output logic                     s_axi_arready_o,
  output logic [31:0]              s_axi_rdata_o,
  output logic [1:0]               s_axi_rresp_o,
  output logic                     s_axi_rvalid_o,
  input  wire logic                s_axi_rready_i,
  input  wire logic [2:0]          gen_raw_i,
  input  wire logic                tb_boundary_i,
  input  wire logic                fault_i,
  output logic [2:0]               pair_high_output_o,
  output logic [2:0]               pair_low_output_o,
  output pwm_out_pkg::reg16_t      duty_value_one_o,
  output pwm_out_pkg::reg16_t      duty_value_two_o,
  output pwm_out_pkg::reg16_t      duty_value_three_o
);
  import pwm_out_pkg::*;

  localparam logic [2:0] PAIR_EN = 3'((1 << PAIR_COUNT) - 1);

  // Bus slave state
  addr_t       aw_addr_q;
  logic        aw_full_q;
  logic        awready_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        w_full_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  addr_t       rd_addr_q;

  // Register file and block state
  reg16_t      dt_sel_q;
  reg16_t      flt_q;
  reg16_t      ovd_q;
  reg16_t      ovd_eff_q;
  reg16_t      dt_cfg_q;
  reg16_t      upd_q;
  reg16_t      dc_buf_q [3];
  reg16_t      dc_act_q [3];
  logic        flt_latch_q;
  logic        cyc_hold_q;
  logic [5:0]  pins_q;
  logic [5:0]  gen_pins;

  wire logic [5:0] pin_mask = {{2{PAIR_EN[2]}}, {2{PAIR_EN[1]}},
                               {2{PAIR_EN[0]}}};
  wire reg16_t dt_msk  = DT_SEL_MASK & {10'h000, pin_mask};
  wire reg16_t flt_msk = FLT_MASK & {2'h0, pin_mask, 5'h10, PAIR_EN};
  wire reg16_t ovd_msk = OVD_MASK & {2'h0, pin_mask, 2'h0, pin_mask};

  // Write channel
  wire logic aw_hs    = s_axi_awvalid_i && awready_q;
  wire logic w_hs     = s_axi_wvalid_i && wready_q;
  wire logic do_write = aw_full_q && w_full_q && !bvalid_q;
  wire logic aw_full_d = aw_full_q ? !do_write : aw_hs;
  wire logic w_full_d  = w_full_q ? !do_write : w_hs;
  wire logic wr_dt_sel = do_write && aw_addr_q == ADDR_DT_SEL;
  wire logic wr_flt    = do_write && aw_addr_q == ADDR_FLT;
  wire logic wr_ovd    = do_write && aw_addr_q == ADDR_OVD;
  wire logic wr_dt_cfg = do_write && aw_addr_q == ADDR_DT_CFG;
  wire logic wr_upd    = do_write && aw_addr_q == ADDR_UPD;
  wire logic wr_stat   = do_write && aw_addr_q == ADDR_STAT;
  wire logic [2:0] wr_dc = {3{do_write}} & {aw_addr_q == ADDR_DC3,
                                            aw_addr_q == ADDR_DC2,
                                            aw_addr_q == ADDR_DC1};
  wire logic wr_hit = wr_dt_sel || wr_flt || wr_ovd || wr_dt_cfg ||
                      wr_upd || wr_stat || (|wr_dc);

  // Read channel
  wire logic ar_hs    = s_axi_arvalid_i && arready_q;
  wire logic rvalid_d = ar_hs || (rvalid_q && !s_axi_rready_i);
  wire addr_t ra      = s_axi_araddr_i;
  wire reg16_t stat_word = {2'h0, pins_q, 5'h00, fault_i, cyc_hold_q,
                            flt_latch_q};
  wire logic rd_hit = ra == ADDR_DT_SEL || ra == ADDR_FLT ||
                      ra == ADDR_OVD || ra == ADDR_DC1 || ra == ADDR_DC2 ||
                      ra == ADDR_DC3 || ra == ADDR_DT_CFG ||
                      ra == ADDR_UPD || ra == ADDR_STAT;
  wire reg16_t rd_val =
    (ra == ADDR_DT_SEL) ? (dt_sel_q & dt_msk) :
    (ra == ADDR_FLT)    ? (flt_q & flt_msk) :
    (ra == ADDR_OVD)    ? (ovd_q & ovd_msk) :
    (ra == ADDR_DC1)    ? dc_buf_q[0] :
    (ra == ADDR_DC2)    ? dc_buf_q[1] :
    (ra == ADDR_DC3)    ? dc_buf_q[2] :
    (ra == ADDR_DT_CFG) ? dt_cfg_q :
    (ra == ADDR_UPD)    ? upd_q :
    (ra == ADDR_STAT)   ? stat_word : 16'h0000;

  // Control decode
  wire logic override_sync_enable    = upd_q[UPD_OVERRIDE_SYNC_ENABLE_BIT];
  wire logic immediate_duty_update      = upd_q[UPD_IUE_BIT];
  wire logic cyc_mode = flt_q[FLT_MODE_BIT];
  // Software may release the latch only once the fault input has gone away
  wire logic latch_clr = wr_stat && w_strb_q[0] &&
                         w_data_q[STAT_LATCH_BIT] && !fault_i;
  wire logic fault_act = fault_i || flt_latch_q || cyc_hold_q;
  wire logic [2:0] pair_flt = {3{fault_act}} & flt_q[2:0] & PAIR_EN;
  wire logic [5:0] flt_force = {{2{pair_flt[2]}}, {2{pair_flt[1]}},
                                {2{pair_flt[0]}}};
  wire logic [5:0] ovd_sel = ovd_eff_q[OVD_SEL_LSB +: 6];
  wire logic [5:0] ovd_lvl = ovd_eff_q[5:0];
  wire logic [5:0] flt_lvl = flt_q[FLT_LVL_LSB +: 6];
  wire logic [5:0] drive_val = (ovd_sel & gen_pins) |
                               (~ovd_sel & ovd_lvl);
  wire logic [5:0] pin_d = ((flt_force & flt_lvl) |
                            (~flt_force & drive_val)) &
                           pin_mask;

  genvar g;
  for (g = 0; g < 3; g++)
  begin : g_pair
    dead_time_pair u_dt (
      .mclk_i      (mclk_i),
      .sys_rst_i   (sys_rst_i),
      .raw_i       (gen_raw_i[g]),
      .act_sel_i   (dt_sel_q[2*g+1]),
      .inact_sel_i (dt_sel_q[2*g]),
      .dt_cfg_i    (dt_cfg_q),
      .high_o      (gen_pins[2*g+1]),
      .low_o       (gen_pins[2*g])
    );
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      aw_full_q <= 1'b0;
      awready_q <= 1'b0;
      w_full_q  <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      awready_q <= !aw_full_d;
      w_full_q  <= w_full_d;
      wready_q  <= !w_full_d;
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready_i)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (aw_hs)
      aw_addr_q <= s_axi_awaddr_i;
    if (w_hs)
    begin
      w_data_q <= s_axi_wdata_i;
      w_strb_q <= s_axi_wstrb_i;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
      rd_addr_q <= '0;
    end
    else
    begin
      arready_q <= !rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_hs)
      begin
        rdata_q   <= {16'h0000, rd_val};
        rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rd_addr_q <= ra;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      dt_sel_q <= DT_SEL_RST;
      flt_q    <= FLT_RST;
      ovd_q    <= OVD_RST;
      dt_cfg_q <= DT_CFG_RST;
      upd_q    <= UPD_RST;
    end
    else
    begin
      if (wr_dt_sel)
        dt_sel_q <= merge16(dt_sel_q, w_data_q, w_strb_q) & DT_SEL_MASK;
      if (wr_flt)
        flt_q <= merge16(flt_q, w_data_q, w_strb_q) & FLT_MASK;
      if (wr_ovd)
        ovd_q <= merge16(ovd_q, w_data_q, w_strb_q) & OVD_MASK;
      if (wr_dt_cfg)
        dt_cfg_q <= merge16(dt_cfg_q, w_data_q, w_strb_q);
      if (wr_upd)
        upd_q <= merge16(upd_q, w_data_q, w_strb_q) & UPD_MASK;
    end
  end

  // Duty buffers always take writes; the active copy follows per update mode
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < 3; i++)
      begin
        dc_buf_q[i] <= DC_RST;
        dc_act_q[i] <= DC_RST;
      end
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (wr_dc[i])
          dc_buf_q[i] <= merge16(dc_buf_q[i], w_data_q, w_strb_q);
        if (wr_dc[i] && immediate_duty_update)
          dc_act_q[i] <= merge16(dc_buf_q[i], w_data_q, w_strb_q);
        else if (tb_boundary_i)
          dc_act_q[i] <= dc_buf_q[i];
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      ovd_eff_q   <= OVD_RST;
      flt_latch_q <= 1'b0;
      cyc_hold_q  <= 1'b0;
      pins_q      <= '0;
    end
    else
    begin
      if (!override_sync_enable || tb_boundary_i)
        ovd_eff_q <= ovd_q;
      // A new fault in the same cycle as a release keeps the latch set
      if (fault_i && !cyc_mode)
        flt_latch_q <= 1'b1;
      else if (latch_clr)
        flt_latch_q <= 1'b0;
      if (fault_i && cyc_mode)
        cyc_hold_q <= 1'b1;
      else if (tb_boundary_i || !cyc_mode)
        cyc_hold_q <= 1'b0;
      pins_q <= pin_d;
    end
  end

  assign s_axi_awready_o    = awready_q;
  assign s_axi_wready_o     = wready_q;
  assign s_axi_bvalid_o     = bvalid_q;
  assign s_axi_bresp_o      = bresp_q;
  assign s_axi_arready_o    = arready_q;
  assign s_axi_rvalid_o     = rvalid_q;
  assign s_axi_rdata_o      = rdata_q;
  assign s_axi_rresp_o      = rresp_q;
  assign pair_high_output_o = {pins_q[5], pins_q[3], pins_q[1]};
  assign pair_low_output_o  = {pins_q[4], pins_q[2], pins_q[0]};
  assign duty_value_one_o   = dc_act_q[0];
  assign duty_value_two_o   = dc_act_q[1];
  assign duty_value_three_o = dc_act_q[2];

  property p_sel_read_zero;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (rvalid_q && rd_addr_q == ADDR_DT_SEL) |-> rdata_q[31:6] == '0;
  endproperty
  a_sel_read_zero: assert property (p_sel_read_zero)
    else $error("dead-time select upper bits not zero");

  property p_fault_level;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (fault_i && flt_q[0]) |=> pair_high_output_o[0] == $past(flt_q[9]) &&
                              pair_low_output_o[0] == $past(flt_q[8]);
  endproperty
  a_fault_level: assert property (p_fault_level)
    else $error("fault level not forced on pair one");

  property p_latch_hold;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (fault_i && !cyc_mode) ##1 (!latch_clr) [*3] |=> flt_latch_q;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched fault released without clear");

  property p_cycle_release;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (cyc_hold_q && cyc_mode && tb_boundary_i && !fault_i) |=> !cyc_hold_q;
  endproperty
  a_cycle_release: assert property (p_cycle_release)
    else $error("cycle-by-cycle fault not released at boundary");

  property p_manual_pin;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (!ovd_eff_q[9] && !flt_force[1]) |=>
      pair_high_output_o[0] == $past(ovd_eff_q[1]);
  endproperty
  a_manual_pin: assert property (p_manual_pin)
    else $error("manual level not driven on pair one high pin");

  property p_gen_pin;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (ovd_eff_q[8] && !flt_force[0]) |=>
      pair_low_output_o[0] == $past(gen_pins[0]);
  endproperty
  a_gen_pin: assert property (p_gen_pin)
    else $error("generator not driving pair one low pin");

  property p_fault_off;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (fault_i && !flt_q[1] && ovd_eff_q[11] && PAIR_EN[1]) |=>
      pair_high_output_o[1] == $past(gen_pins[3]);
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("disabled pair two affected by fault");

  property p_override_sync_enable_hold;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (override_sync_enable && !tb_boundary_i) |=> $stable(ovd_eff_q);
  endproperty
  a_override_sync_enable_hold: assert property (p_override_sync_enable_hold)
    else $error("override applied before time base boundary");

  property p_duty_hold;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (wr_dc[0] && !immediate_duty_update && !tb_boundary_i) |=> dc_buf_q[0] != dc_act_q[0] ||
                                             $stable(dc_act_q[0]);
  endproperty
  a_duty_hold: assert property (p_duty_hold)
    else $error("duty changed outside boundary without immediate update");

  property p_duty_write;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (wr_dc[1] && w_strb_q[1:0] == 2'h3) |=>
      dc_buf_q[1] == $past(w_data_q[15:0]);
  endproperty
  a_duty_write: assert property (p_duty_write)
    else $error("duty value two not stored");

  property p_unused_pairs;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (pins_q & ~pin_mask) == 6'h00;
  endproperty
  a_unused_pairs: assert property (p_unused_pairs)
    else $error("absent pin pair driven");

  property p_fault_pins;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (flt_force[1] && flt_q[9]) |=> pair_high_output_o[0];
  endproperty
  a_fault_pins: assert property (p_fault_pins)
    else $error("fault level one not driven active");

endmodule : motor_pwm_output_stage

/* dv/gate_fault_side.sv */
// Far-side model: external fault source and gate-driver overlap watch
`timescale 1ns/1ps
module gate_fault_side
(
  input  wire logic       mclk_i,
  input  wire logic [2:0] high_i,
  input  wire logic [2:0] low_i,
  output logic            fault_o,
  output logic            overlap_o
);
  initial fault_o = 1'b0;
  initial overlap_o = 1'b0;
  // A leg whose two switches conduct together shorts the supply
  always @(posedge mclk_i)
    if (|(high_i & low_i))
      overlap_o <= 1'b1;
  // Fault source changes only just after an edge, like real sync logic
  task automatic drive_fault(input logic v);
    @(posedge mclk_i);
    fault_o <= v;
  endtask : drive_fault
endmodule : gate_fault_side

/* dv/tb.sv */
// Self-checking bench for the PWM output stage
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module tb;
  import pwm_out_pkg::*;
  logic mclk_i = 0, sys_rst_i = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic bnd = 0, fault, overlap;
  addr_t awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [1:0] bresp, rresp, last_resp;
  logic [2:0] raw = '0, high, low;
  reg16_t d1, d2, d3;
  reg16_t dv [3] = '{16'ha5c3, 16'h5a3c, 16'hffff};
  int miscompares = 0, total_checks = 0, cycles = 0, da, db;
  initial forever #5 mclk_i = ~mclk_i;
  motor_pwm_output_stage i_motor_pwm_output_stage (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .gen_raw_i(raw), .tb_boundary_i(bnd),
    .fault_i(fault), .pair_high_output_o(high), .pair_low_output_o(low),
    .duty_value_one_o(d1), .duty_value_two_o(d2), .duty_value_three_o(d3));
  gate_fault_side i_gate_fault_side (.mclk_i(mclk_i), .high_i(high),
    .low_i(low), .fault_o(fault), .overlap_o(overlap));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  // Address and data are offered together; each drops once taken
  task automatic axi_wr(input addr_t a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge mclk_i);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    while (1)
    begin
      @(posedge mclk_i);
      if (aw && awready)
      begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready)
      begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid)
      begin
        last_resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr
  task automatic axi_rd(input addr_t a);
    @(posedge mclk_i);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (1)
    begin
      @(posedge mclk_i);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rd = rdata;
        last_resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wait_cyc
  task automatic pulse_boundary();
    @(posedge mclk_i);
    bnd <= 1'b1;
    @(posedge mclk_i);
    bnd <= 1'b0;
    wait_cyc(3);
  endtask : pulse_boundary
  // Cycles from a raw rising edge until the high pin turns on
  task automatic rise_delay(output int n);
    n = 0;
    @(posedge mclk_i);
    raw <= 3'b001;
    while (high[0] !== 1'b1 && n < 200)
    begin
      @(posedge mclk_i);
      n++;
    end
    raw <= 3'b000;
    wait_cyc(60);
  endtask : rise_delay
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end
  initial
  begin
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    wait_cyc(5);
    axi_rd(ADDR_OVD); `CHK(rd, 32'h3f00)
    for (int i = 0; i < 3; i++)
    begin
      axi_rd(addr_t'(ADDR_DC1 + 4 * i)); `CHK(rd, 32'h0)
      axi_wr(addr_t'(ADDR_DC1 + 4 * i), {16'hdead, dv[i]});
      axi_rd(addr_t'(ADDR_DC1 + 4 * i)); `CHK(rd, {16'h0, dv[i]})
    end
    `CHK(d1, 16'h0)
    pulse_boundary();
    `CHK({d1, d2, d3}, {dv[0], dv[1], dv[2]})
    axi_wr(ADDR_DT_SEL, 32'hffff);
    axi_rd(ADDR_DT_SEL); `CHK(rd, 32'h3f)
    axi_wr(8'h40, 32'h1); `CHK(last_resp, RESP_SLVERR)
    axi_rd(8'h40); `CHK({rd, last_resp}, {32'h0, RESP_SLVERR})
    axi_wr(ADDR_OVD, 32'h15); wait_cyc(4);
    `CHK({high, low}, 6'b000111)
    axi_wr(ADDR_OVD, 32'h2a); wait_cyc(4);
    `CHK({high, low}, 6'b111000)
    // Latched mode, pair one only under fault control
    axi_wr(ADDR_OVD, 32'h3f00);
    axi_wr(ADDR_FLT, 32'h2a01);
    i_gate_fault_side.drive_fault(1'b1); wait_cyc(4);
    `CHK({high, low}, 6'b001110)
    i_gate_fault_side.drive_fault(1'b0); pulse_boundary();
    `CHK({high, low}, 6'b001110)
    axi_wr(ADDR_STAT, 32'h1); wait_cyc(4);
    `CHK({high, low}, 6'b000111)
    // Cycle mode on top of manual drive: fault must win
    axi_wr(ADDR_OVD, 32'h0);
    axi_wr(ADDR_FLT, 32'h1587);
    i_gate_fault_side.drive_fault(1'b1); wait_cyc(4);
    `CHK({high, low}, 6'b000111)
    i_gate_fault_side.drive_fault(1'b0); wait_cyc(4);
    `CHK({high, low}, 6'b000111)
    pulse_boundary();
    `CHK({high, low}, 6'b000000)
    axi_wr(ADDR_FLT, 32'h0);
    axi_wr(ADDR_OVD, 32'h3f00);
    // Unit A: 8 steps of 2 cycles; unit B: 1 step of 8 cycles
    axi_wr(ADDR_DT_CFG, 32'hc148);
    axi_wr(ADDR_DT_SEL, 32'h0); wait_cyc(60);
    rise_delay(da);
    axi_wr(ADDR_DT_SEL, 32'h2);
    rise_delay(db);
    `CHK(da - db, 8)
    // One step of one cycle: pin port rises four cycles after the step
    axi_wr(ADDR_DT_CFG, 32'h1);
    axi_wr(ADDR_DT_SEL, 32'h0);
    rise_delay(da);
    `CHK(da, 5)
    // Synchronised override waits for the boundary
    axi_wr(ADDR_UPD, 32'h1);
    axi_wr(ADDR_OVD, 32'h2a);
    wait_cyc(4);
    `CHK({high, low}, 6'b000111)
    pulse_boundary();
    `CHK({high, low}, 6'b111000)
    // Immediate update skips the boundary
    axi_wr(ADDR_UPD, 32'h2);
    axi_wr(ADDR_DC2, 32'h1234);
    `CHK(d2, 16'h1234)
    `CHK(overlap, 1'b0)
    complete_run();
  end
endmodule : tb

/* inc/pwm_out_pkg.sv */
// Constants, types and helpers shared by the PWM output stage
package pwm_out_pkg;

  typedef logic [15:0] reg16_t;
  typedef logic [8:0]  dt_cnt_t;
  typedef logic [7:0]  addr_t;

  // Register byte addresses on the AXI4-Lite slave
  localparam addr_t ADDR_DT_SEL  = 8'h00;
  localparam addr_t ADDR_FLT     = 8'h04;
  localparam addr_t ADDR_OVD     = 8'h08;
  localparam addr_t ADDR_DC1     = 8'h0c;
  localparam addr_t ADDR_DC2     = 8'h10;
  localparam addr_t ADDR_DC3     = 8'h14;
  localparam addr_t ADDR_DT_CFG  = 8'h18;
  localparam addr_t ADDR_UPD     = 8'h1c;
  localparam addr_t ADDR_STAT    = 8'h20;

  // Implemented bits and reset values
  localparam reg16_t DT_SEL_MASK = 16'h003f;
  localparam reg16_t FLT_MASK    = 16'h3f87;
  localparam reg16_t OVD_MASK    = 16'h3f3f;
  localparam reg16_t UPD_MASK    = 16'h0003;
  localparam reg16_t DT_SEL_RST  = 16'h0000;
  localparam reg16_t FLT_RST     = 16'h0000;
  localparam reg16_t OVD_RST     = 16'h3f00;
  localparam reg16_t DC_RST      = 16'h0000;
  localparam reg16_t DT_CFG_RST  = 16'h0000;
  localparam reg16_t UPD_RST     = 16'h0000;

  // Field positions
  localparam int FLT_MODE_BIT   = 7;
  localparam int FLT_LVL_LSB    = 8;
  localparam int OVD_SEL_LSB    = 8;
  localparam int DT_A_VAL_LSB   = 0;
  localparam int DT_A_PS_LSB    = 6;
  localparam int DT_B_VAL_LSB   = 8;
  localparam int DT_B_PS_LSB    = 14;
  localparam int UPD_OVERRIDE_SYNC_ENABLE_BIT  = 0;
  localparam int UPD_IUE_BIT    = 1;
  localparam int STAT_LATCH_BIT = 0;
  localparam int STAT_CYC_BIT   = 1;
  localparam int STAT_FIN_BIT   = 2;
  localparam int STAT_PIN_LSB   = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [0:0] {DT_IDLE, DT_WAIT} dt_state_t;

  // Dead time in clock cycles: value times a step of 1, 2, 4 or 8 cycles
  function automatic dt_cnt_t dead_cycles(input logic [5:0] val,
                                          input logic [1:0] ps);
    dead_cycles = {3'h0, val} << ps;
  endfunction : dead_cycles

  // Byte-lane merge of a 16-bit register with AXI write data
  function automatic reg16_t merge16(input reg16_t     old,
                                     input logic [31:0] data,
                                     input logic [3:0]  strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8],
               strb[0] ? data[7:0]  : old[7:0]};
  endfunction : merge16

endpackage : pwm_out_pkg
